//--- include/tec_defines.svh
// Constants for the 8-bit timer/event counter
// Notes on behaviour
// - One 8-bit up counter with a separately written preload value.
// - Control bits 7:6 pick the mode: 00 comparator events, 01 pin events, 10 timer, 11 pulse-width capture.
// - Control bit 4 lets the counter advance when one and halts it when zero.
// - In event modes control bit 3 set counts falling edges, cleared counts rising edges.
// - In capture mode bit 3 set starts on rising and stops on falling, cleared the reverse.
// - Control bits 2:0 divide the system clock by two to the power of the field.
// - Event sources bypass the prescaler and each qualifying edge counts once directly.
// - Timer mode adds one on each high-to-low transition of the prescaled clock while enabled.
// - Overflow raises the timer interrupt, reloads from preload and keeps counting.
// - The interrupt is held back while its enable bit is zero, but overflow and reload still happen.
// - In event modes counting goes on during power-down and overflow also raises wake-up.
// - Reading the value register returns the live count, writing it sets the preload.
// - Control bit 5 is unimplemented, reads zero and ignores writes.
// - In capture mode setting enable only arms; counting starts at the selected start edge.
// - In capture mode the return edge clears enable, stops counting and later edges are ignored.
`ifndef TEC_DEFINES_SVH
`define TEC_DEFINES_SVH
// ============================================================
// Register byte addresses
`define TEC_ADDR_VALUE   8'h00
`define TEC_ADDR_CTRL    8'h04
`define TEC_ADDR_STATUS  8'h08
`define TEC_ADDR_MASK    8'h0C
// ============================================================
// Control fields
`define TEC_MODE_HI      7
`define TEC_MODE_LO      6
`define TEC_BIT_UNUSED   5
`define TEC_BIT_EN       4
`define TEC_BIT_EDGE     3
`define TEC_PS_HI        2
`define TEC_CTRL_RESET   8'h08
`define TEC_CTRL_WMASK   8'hDF
// ============================================================
// Status bits
`define TEC_ST_OVF       0
`define TEC_ST_WAKE      1
`define TEC_ST_MASK      2'h3
`endif

//--- include/tec_pkg.sv
// Types shared by the timer/event counter
package tec_pkg;
    typedef enum logic [1:0] {
        TEC_MODE_CMP   = 2'b00,
        TEC_MODE_PIN   = 2'b01,
        TEC_MODE_TIMER = 2'b10,
        TEC_MODE_PWC   = 2'b11
    } tec_mode_t;

    typedef enum logic [1:0] {
        TEC_PW_IDLE = 2'b00,
        TEC_PW_ARM  = 2'b01,
        TEC_PW_RUN  = 2'b10
    } tec_pw_state_t;

    typedef struct packed {
        logic       step;
        logic [7:0] preload;
    } tec_step_t;
endpackage : tec_pkg

//--- rtl/tec_prescaler.sv
// Power-of-two prescaler producing a one-cycle falling-edge tick
`timescale 1ns/100ps
module tec_prescaler #(
    parameter int STAGES = 7
) (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       run,
    input  wire logic [2:0] sel,
    output logic            tick
);
    logic [STAGES-1:0] div_r;
    logic [STAGES-1:0] div_nxt;
    logic              tap_prev_r;
    logic              tap;

    always_comb begin
        div_nxt = run ? div_r + {{(STAGES-1){1'b0}}, 1'b1} : '0;
        tap     = (sel == 3'h0) ? 1'b0 : div_r[sel - 3'h1];
        // Undivided clock: every cycle is a high-to-low step
        tick    = run & ((sel == 3'h0) | (tap_prev_r & ~tap));
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_r      <= '0;
            tap_prev_r <= 1'b0;
        end else begin
            div_r      <= div_nxt;
            tap_prev_r <= tap;
        end
    end
endmodule : tec_prescaler

//--- rtl/tec_timer.sv
// Timer/event counter top with APB register slave
`timescale 1ns/100ps
`include "tec_defines.svh"
module tec_timer
    import tec_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        comparator_one_output,
    input  wire logic        ext_event_pin,
    input  wire logic        power_down,
    output logic             irq,
    output logic             wake_req
);
    // ============================================================
    // Registers
    logic [WIDTH-1:0] count_r,   count_nxt;
    logic [WIDTH-1:0] preload_r, preload_nxt;
    logic [7:0]       ctrl_r,    ctrl_nxt;
    logic [1:0]       status_r,  status_nxt;
    logic [1:0]       mask_r,    mask_nxt;
    logic [31:0]      prdata_nxt;
    logic             irq_r,     irq_nxt;
    logic             wake_r,    wake_nxt;
    logic             cmp_s1_r, cmp_s2_r, cmp_s3_r;
    logic             pin_s1_r, pin_s2_r, pin_s3_r;
    tec_pw_state_t    pw_r,      pw_nxt;

    tec_mode_t        mode;
    logic             en, edge_sel, wr_acc, rd_acc, ps_tick;
    logic             ev_in, ev_prev, rise, fall, start_edge, stop_edge;
    tec_step_t        stp;
    logic             ovf;

    function automatic logic valid_addr(input logic [7:0] a);
        valid_addr = (a == `TEC_ADDR_VALUE) | (a == `TEC_ADDR_CTRL) |
                     (a == `TEC_ADDR_STATUS) | (a == `TEC_ADDR_MASK);
    endfunction : valid_addr

    assign mode     = tec_mode_t'(ctrl_r[`TEC_MODE_HI:`TEC_MODE_LO]);
    assign en       = ctrl_r[`TEC_BIT_EN];
    assign edge_sel = ctrl_r[`TEC_BIT_EDGE];
    assign wr_acc   = psel & penable & pwrite;
    assign rd_acc   = psel & penable & ~pwrite;

    // ============================================================
    // Input synchronisers; stage two feeds the edge detector directly and also via stage three
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_s1_r <= 1'b0;
            cmp_s2_r <= 1'b0;
            cmp_s3_r <= 1'b0;
            pin_s1_r <= 1'b0;
            pin_s2_r <= 1'b0;
            pin_s3_r <= 1'b0;
        end else begin
            cmp_s1_r <= comparator_one_output;
            cmp_s2_r <= cmp_s1_r;
            cmp_s3_r <= cmp_s2_r;
            pin_s1_r <= ext_event_pin;
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
        end
    end

    always_comb begin
        ev_in      = (mode == TEC_MODE_CMP) ? cmp_s2_r : pin_s2_r;
        ev_prev    = (mode == TEC_MODE_CMP) ? cmp_s3_r : pin_s3_r;
        rise       = ev_in & ~ev_prev;
        fall       = ~ev_in & ev_prev;
        start_edge = edge_sel ? rise : fall;
        stop_edge  = edge_sel ? fall : rise;
    end

    // Prescaler runs only in modes that use the system clock
    tec_prescaler #(.STAGES(7)) u_ps (
        .pclk    (pclk),
        .presetn (presetn),
        .run     (en & mode[1]),
        .sel     (ctrl_r[`TEC_PS_HI:0]),
        .tick    (ps_tick)
    );

    // ============================================================
    // Counting and control
    always_comb begin
        pw_nxt   = pw_r;
        stp.step = 1'b0;
        stp.preload = preload_r;
        ctrl_nxt = ctrl_r;
        case (mode)
            TEC_MODE_CMP, TEC_MODE_PIN: begin
                // Prescaler bypassed, edges count directly
                stp.step = en & (edge_sel ? fall : rise);
                pw_nxt   = TEC_PW_IDLE;
            end
            TEC_MODE_TIMER: begin
                stp.step = en & ps_tick;
                pw_nxt   = TEC_PW_IDLE;
            end
            TEC_MODE_PWC: begin
                case (pw_r)
                    TEC_PW_IDLE: if (en) begin
                        pw_nxt = TEC_PW_ARM;
                    end
                    TEC_PW_ARM: begin
                        if (!en) pw_nxt = TEC_PW_IDLE;
                        else if (start_edge) pw_nxt = TEC_PW_RUN;
                    end
                    TEC_PW_RUN: begin
                        if (!en) begin
                            pw_nxt = TEC_PW_IDLE;
                        end else if (stop_edge) begin
                            pw_nxt = TEC_PW_IDLE;
                            ctrl_nxt[`TEC_BIT_EN] = 1'b0;
                        end else begin
                            stp.step = ps_tick;
                        end
                    end
                    default: pw_nxt = TEC_PW_IDLE;
                endcase
            end
            default: pw_nxt = TEC_PW_IDLE;
        endcase
        // Software write lands after hardware clear of enable
        if (wr_acc && paddr == `TEC_ADDR_CTRL) begin
            ctrl_nxt = pwdata[7:0] & `TEC_CTRL_WMASK;
        end
    end

    always_comb begin
        ovf         = stp.step & (&count_r);
        count_nxt   = count_r;
        preload_nxt = preload_r;
        if (ovf) begin
            count_nxt = stp.preload;
        end else if (stp.step) begin
            count_nxt = count_r + {{(WIDTH-1){1'b0}}, 1'b1};
        end
        if (wr_acc && paddr == `TEC_ADDR_VALUE) begin
            preload_nxt = pwdata[WIDTH-1:0];
        end
    end

    // ============================================================
    // Status, mask and interrupt; a new event beats a same-cycle clear
    always_comb begin
        status_nxt = status_r;
        mask_nxt   = mask_r;
        if (wr_acc && paddr == `TEC_ADDR_STATUS) begin
            status_nxt = status_r & ~pwdata[1:0];
        end
        if (wr_acc && paddr == `TEC_ADDR_MASK) begin
            mask_nxt = pwdata[1:0];
        end
        if (ovf) begin
            status_nxt[`TEC_ST_OVF] = 1'b1;
        end
        if (ovf && power_down && !mode[1]) begin
            status_nxt[`TEC_ST_WAKE] = 1'b1;
        end
        irq_nxt  = |(status_nxt & mask_nxt);
        wake_nxt = status_nxt[`TEC_ST_WAKE] & mask_nxt[`TEC_ST_WAKE];
    end

    // ============================================================
    // APB read data, zero wait states
    always_comb begin
        prdata_nxt = 32'h0000_0000;
        if (psel && !penable && !pwrite) begin
            case (paddr)
                `TEC_ADDR_VALUE:  prdata_nxt = {{(32-WIDTH){1'b0}}, count_r};
                `TEC_ADDR_CTRL:   prdata_nxt = {24'h000000, ctrl_r};
                `TEC_ADDR_STATUS: prdata_nxt = {30'h0, status_r};
                `TEC_ADDR_MASK:   prdata_nxt = {30'h0, mask_r};
                default:          prdata_nxt = 32'h0000_0000;
            endcase
        end else if (rd_acc) begin
            prdata_nxt = prdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_r   <= '0;
            preload_r <= '0;
            ctrl_r    <= `TEC_CTRL_RESET;
            status_r  <= 2'h0;
            mask_r    <= 2'h0;
            irq_r     <= 1'b0;
            wake_r    <= 1'b0;
            pw_r      <= TEC_PW_IDLE;
            prdata    <= 32'h0000_0000;
            pslverr   <= 1'b0;
        end else begin
            count_r   <= count_nxt;
            preload_r <= preload_nxt;
            ctrl_r    <= ctrl_nxt;
            status_r  <= status_nxt;
            mask_r    <= mask_nxt;
            irq_r     <= irq_nxt;
            wake_r    <= wake_nxt;
            pw_r      <= pw_nxt;
            prdata    <= prdata_nxt;
            pslverr   <= psel & ~penable & ~valid_addr(paddr);
        end
    end

    assign pready   = 1'b1;
    assign irq      = irq_r;
    assign wake_req = wake_r;

    // ============================================================
    // Checks
    property p_ovf_reload;
        @(posedge pclk) disable iff (!presetn)
        (stp.step && count_r == 8'hFF) |=> (count_r == $past(preload_r));
    endproperty
    a_ovf_reload: assert property (p_ovf_reload) else $error("no reload on overflow");

    property p_ovf_sticky;
        @(posedge pclk) disable iff (!presetn)
        ovf |=> status_r[0];
    endproperty
    a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow flag not set");

    property p_irq_mask;
        @(posedge pclk) disable iff (!presetn)
        (!mask_r[`TEC_ST_OVF] && !(status_r[`TEC_ST_WAKE] && mask_r[`TEC_ST_WAKE])) |-> !irq;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("irq while masked");

    property p_halt;
        @(posedge pclk) disable iff (!presetn)
        !en |=> $stable(count_r);
    endproperty
    a_halt: assert property (p_halt) else $error("counted while disabled");

    property p_bit5;
        @(posedge pclk) disable iff (!presetn)
        1'b1 |-> !ctrl_r[`TEC_BIT_UNUSED];
    endproperty
    a_bit5: assert property (p_bit5) else $error("bit 5 set");

    property p_inc_one;
        @(posedge pclk) disable iff (!presetn)
        (stp.step && count_r != 8'hFF) |=> count_r == $past(count_r) + 8'h01;
    endproperty
    a_inc_one: assert property (p_inc_one) else $error("step not by one");

    property p_arm_hold;
        @(posedge pclk) disable iff (!presetn)
        (mode == TEC_MODE_PWC && pw_r == TEC_PW_ARM) |-> !stp.step;
    endproperty
    a_arm_hold: assert property (p_arm_hold) else $error("counted before start edge");

    property p_pwc_stop;
        @(posedge pclk) disable iff (!presetn)
        (mode == TEC_MODE_PWC && pw_r == TEC_PW_RUN && en && stop_edge && !wr_acc) |=> !en && pw_r == TEC_PW_IDLE;
    endproperty
    a_pwc_stop: assert property (p_pwc_stop) else $error("capture did not stop");

    property p_event_direct;
        @(posedge pclk) disable iff (!presetn)
        (!mode[1] && en && (edge_sel ? fall : rise)) |-> stp.step;
    endproperty
    a_event_direct: assert property (p_event_direct) else $error("event edge missed");
endmodule : tec_timer

//--- tb/tec_event_src.sv
// Behavioural source of comparator and pin events
`timescale 1ns/100ps
module tec_event_src (
    input  wire logic pclk,
    output logic      cmp_out,
    output logic      pin_out
);
    initial begin
        cmp_out = 1'b0;
        pin_out = 1'b0;
    end

    // Held six cycles so each level clears all three synchroniser stages and is counted before the task returns
    task automatic set_line(input logic sel_pin, input logic lvl);
        @(posedge pclk);
        if (sel_pin) begin
            pin_out <= lvl;
        end else begin
            cmp_out <= lvl;
        end
        repeat (6) @(posedge pclk);
    endtask : set_line
endmodule : tec_event_src

//--- tb/tb_top.sv
// Self-checking testbench for the timer/event counter
`timescale 1ns/100ps
`include "tec_defines.svh"
module tb_top;
    import tec_pkg::*;
    localparam logic [7:0] ADR_VAL = `TEC_ADDR_VALUE;
    localparam logic [7:0] ADR_CTL = `TEC_ADDR_CTRL;
    localparam logic [7:0] ADR_ST  = `TEC_ADDR_STATUS;
    localparam logic [7:0] ADR_MSK = `TEC_ADDR_MASK;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        cmp_line;
    logic        pin_line;
    logic        power_down;
    logic        irq;
    logic        wake_req;
    logic [31:0] v0;
    logic [31:0] d;
    logic        e;
    logic [1:0]  kk;
    int          failures;
    int          compares;

    initial pclk = 1'b0;
    always #25 pclk = ~pclk;

    tec_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .comparator_one_output(cmp_line), .ext_event_pin(pin_line), .power_down(power_down),
        .irq(irq), .wake_req(wake_req));
    tec_event_src src (.pclk(pclk), .cmp_out(cmp_line), .pin_out(pin_line));

    // ============================================================
    // Access and check tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic apb(input logic wr_en, input logic [7:0] adr, input logic [31:0] wd,
                       output logic [31:0] rdat, output logic err);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr_en;
        paddr   <= adr;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // Only the watchdog ends a slave that never answers
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rdat = prdata;
        err  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] adr, input logic [31:0] wd);
        logic [31:0] x;
        logic        er;
        apb(1'b1, adr, wd, x, er);
    endtask : wr

    task automatic rd(input logic [7:0] adr, output logic [31:0] rdat);
        logic er;
        apb(1'b0, adr, 32'h0, rdat, er);
    endtask : rd

    // Preload is 0xF0 throughout the event section
    function automatic logic [31:0] nxt(input logic [31:0] v);
        return (v == 32'hFF) ? 32'hF0 : v + 32'h1;
    endfunction : nxt

    task automatic end_sim;
        $display("Comparisons %0d, mismatches %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_sim

    // ============================================================
    // Watchdog, well above the few thousand cycles the tests need
    initial begin
        repeat (20000) @(posedge pclk);
        failures++;
        end_sim();
    end

    // ============================================================
    // Test sequence
    initial begin
        failures = 0;
        compares = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        power_down = 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd(ADR_CTL, d);
        chk(d, 32'h08);
        rd(ADR_VAL, d);
        chk(d, 32'h0);
        rd(ADR_ST, d);
        chk(d, 32'h0);
        wr(ADR_CTL, 32'h2F);
        rd(ADR_CTL, d);
        chk(d, 32'h0F);
        apb(1'b0, 8'h10, 32'h0, d, e);
        chk({d[30:0], e}, 32'h1);
        chk({31'h0, pready}, 32'h1);
        wr(ADR_VAL, 32'hF0);
        rd(ADR_VAL, d);
        chk(d, 32'h0);
        wr(ADR_VAL, 32'h0);
        // Reads 384 cycles apart: tick count is 384 >> field, mod 256
        for (int n = 0; n < 8; n++) begin
            wr(ADR_CTL, 32'h90 | n);
            rd(ADR_VAL, v0);
            repeat (381) @(posedge pclk);
            rd(ADR_VAL, d);
            chk((d - v0) & 32'hFF, (32'd384 >> n) & 32'hFF);
        end
        wr(ADR_CTL, 32'h80);
        rd(ADR_VAL, v0);
        repeat (50) @(posedge pclk);
        rd(ADR_VAL, d);
        chk(d, v0);
        wr(ADR_VAL, 32'hF0);
        wr(ADR_CTL, 32'h90);
        repeat (300) @(posedge pclk);
        wr(ADR_CTL, 32'h80);
        rd(ADR_ST, d);
        chk(d, 32'h1);
        chk({31'h0, irq}, 32'h0);
        rd(ADR_VAL, d);
        chk({31'h0, d >= 32'hF0}, 32'h1);
        wr(ADR_MSK, 32'h1);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h1);
        wr(ADR_ST, 32'h1);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        rd(ADR_ST, d);
        chk(d, 32'h0);
        // Event modes with prescaler at 128: edges still count one each
        power_down <= 1'b1;
        wr(ADR_MSK, 32'h2);
        for (int k = 0; k < 4; k++) begin
            kk = k[1:0];
            src.set_line(kk[0], kk[1]);
            wr(ADR_CTL, {24'h0, 1'b0, kk[0], 2'b01, kk[1], 3'h7});
            rd(ADR_VAL, v0);
            src.set_line(kk[0], ~kk[1]);
            rd(ADR_VAL, d);
            chk(d, nxt(v0));
            src.set_line(kk[0], kk[1]);
            src.set_line(~kk[0], 1'b1);
            src.set_line(~kk[0], 1'b0);
            rd(ADR_VAL, d);
            chk(d, nxt(v0));
        end
        // Pin rising edges up to overflow while powered down
        wr(ADR_CTL, 32'h57);
        rd(ADR_VAL, v0);
        for (int i = 0; i < 32'h100 - v0; i++) begin
            src.set_line(1'b1, 1'b0);
            src.set_line(1'b1, 1'b1);
        end
        rd(ADR_VAL, d);
        chk(d, 32'hF0);
        rd(ADR_ST, d);
        chk(d, 32'h3);
        chk({30'h0, wake_req, irq}, 32'h3);
        wr(ADR_ST, 32'h3);
        power_down <= 1'b0;
        wr(ADR_VAL, 32'h0);
        // Capture of a 101-cycle pulse; one cycle of slack either side
        for (int k = 0; k < 2; k++) begin
            e = k[0];
            src.set_line(1'b1, ~e);
            wr(ADR_CTL, {24'h0, 4'hD, e, 3'h0});
            rd(ADR_VAL, v0);
            repeat (20) @(posedge pclk);
            rd(ADR_VAL, d);
            chk(d, v0);
            src.set_line(1'b1, e);
            repeat (94) @(posedge pclk);
            src.set_line(1'b1, ~e);
            rd(ADR_CTL, d);
            chk(d, {24'h0, 4'hC, e, 3'h0});
            rd(ADR_VAL, d);
            chk({31'h0, ((d - v0) & 32'hFF) inside {[100:102]}}, 32'h1);
            src.set_line(1'b1, e);
            src.set_line(1'b1, ~e);
            rd(ADR_VAL, v0);
            chk(v0, d);
        end
        end_sim();
    end
endmodule : tb_top
